// *** src/serial_port_pkg.sv ***
// Constants shared by the serial port byte transfer logic
package serial_port_pkg;
    // Special function register addresses
    localparam logic [7:0] SERIAL_DATA_OFFSET = 8'h99;
    localparam logic [7:0] SERIAL_CONTROL_OFFSET = 8'h98;
    // Control register field positions
    localparam int RX_DONE_BIT = 0;
    localparam int TX_DONE_BIT = 1;
    localparam int NINTH_BIT = 2;
    localparam int TX_BUSY_BIT = 3;
    localparam int RX_ENABLE_BIT = 4;
    localparam int MP_CHECK_BIT = 5;
    // Reset values
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    // Frame and oversampling figures
    localparam int DATA_BITS = 8;
    localparam int OVERSAMPLE = 16;
    localparam logic [3:0] SAMPLE_MID = 4'h9;
    localparam logic [3:0] DIV_LAST = 4'hf;
    localparam logic [3:0] TX_LAST_BIT = 4'h9;
    localparam logic [2:0] RX_LAST_BIT = 3'h7;
    // Receiver sequencing
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_e;
endpackage

// *** src/rx_line_filter.sv ***
// Receive pin synchroniser, glitch filter and three-sample majority vote
`timescale 1ns/10ps
module rx_line_filter
    import serial_port_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Line and sample strobe
    input wire logic pinIn,
    input wire logic sampleTick,
    // Filtered level and vote over the last three samples
    output logic level,
    output logic vote
);
    logic sync1_r;
    logic sync2_r;
    logic sync3_r;
    logic level_r;
    logic [1:0] hist_r;

    // Three-stage synchroniser; the first stage feeds only the second
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_r <= 1'b1;
            sync2_r <= 1'b1;
            sync3_r <= 1'b1;
        end
        else
        begin
            sync1_r <= pinIn;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
        end
    end

    // Level only moves once two settled stages agree
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            level_r <= 1'b1;
        else if (sync2_r == sync3_r)
            level_r <= sync2_r;
    end

    // Sample history, one entry per oversample strobe
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            hist_r <= 2'h3;
        else if (sampleTick)
            hist_r <= {hist_r[0], level_r};
    end

    // Majority of two stored samples and the one being taken now
    assign level = level_r;
    assign vote = (hist_r[1] & hist_r[0]) | (hist_r[1] & level_r)
                | (hist_r[0] & level_r);
endmodule

// *** src/serial_port_byte_transfer.sv ***
// Serial port byte transfer: data buffer, done flags, transmitter, receiver
`timescale 1ns/10ps
// Notes on behaviour
// - Writing the data buffer at 99 hex while idle starts sending that byte at once.
// - Frame is start bit, eight data bits, stop bit at the bit rate.
// - Transmit-done flag sets when the frame has completely gone out.
// - Receive-done flag sets by itself when a character has arrived.
// - Reading the data buffer returns the received byte, after receive-done.
// - Sixteen samples per bit, realigned on start edge, majority of three.
// - At mid stop bit, if allowed, store byte and stop bit and set flag.
// - Each timer overflow feeds the baud logic, divided by sixteen per bit.
module serial_port_byte_transfer
    import serial_port_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Special function register access
    input wire logic [7:0] sfrAddr,
    input wire logic sfrWrEn,
    input wire logic sfrRdEn,
    input wire logic [7:0] sfrWrData,
    output logic [7:0] sfrRdData,
    // Bit rate source
    input wire logic timerOverflow,
    // Serial line
    input wire logic receiveLinePin,
    output logic transmitLine,
    // Flag levels for an interrupt controller
    output logic transmitDoneFlag,
    output logic receiveDoneFlag
);
    logic [7:0] rdData_r;
    logic [7:0] rxBuffer_r;
    logic rxDone_r;
    logic txDone_r;
    logic ninth_r;
    logic rxEnable_r;
    logic mpCheck_r;
    logic txBusy_r;
    logic txLine_r;
    logic [9:0] txShift_r;
    logic [3:0] txDiv_r;
    logic [3:0] txBits_r;
    rx_state_e rxState_r;
    logic [3:0] rxCnt_r;
    logic [2:0] rxBits_r;
    logic [7:0] rxShift_r;
    logic prevLevel_r;
    logic lineLevel;
    logic lineVote;

    // Register decode
    logic dataWrite;
    logic ctrlWrite;
    logic dataRead;
    logic ctrlRead;
    logic [7:0] statusWord;
    assign dataWrite = sfrWrEn && (sfrAddr == SERIAL_DATA_OFFSET);
    assign ctrlWrite = sfrWrEn && (sfrAddr == SERIAL_CONTROL_OFFSET);
    assign dataRead = sfrRdEn && (sfrAddr == SERIAL_DATA_OFFSET);
    assign ctrlRead = sfrRdEn && (sfrAddr == SERIAL_CONTROL_OFFSET);
    assign statusWord = {2'h0, mpCheck_r, rxEnable_r, txBusy_r, ninth_r,
                         txDone_r, rxDone_r};

    // Transmit sequencing
    logic txLoad;
    logic txBitEnd;
    logic txFinish;
    logic [9:0] txShiftNext;
    assign txLoad = dataWrite && !txBusy_r;
    assign txBitEnd = txBusy_r && timerOverflow && (txDiv_r == DIV_LAST);
    assign txFinish = txBitEnd && (txBits_r == TX_LAST_BIT);
    assign txShiftNext = {1'b1, txShift_r[9:1]};

    // Receive sequencing
    logic [3:0] rxPhase;
    logic rxMid;
    logic startEdge;
    logic stopMid;
    logic rxCommit;
    assign rxPhase = rxCnt_r + 4'h1;
    assign rxMid = timerOverflow && (rxPhase == SAMPLE_MID);
    assign startEdge = timerOverflow && (rxState_r == RX_IDLE) && rxEnable_r
                     && prevLevel_r && !lineLevel;
    assign stopMid = rxMid && (rxState_r == RX_STOP);
    assign rxCommit = stopMid && !rxDone_r
                    && (!mpCheck_r || lineVote);

    // Flag next values: a hardware set wins over a software clear
    logic rxDone_nxt;
    logic txDone_nxt;
    assign rxDone_nxt = rxCommit
        || (ctrlWrite ? sfrWrData[RX_DONE_BIT] : rxDone_r);
    assign txDone_nxt = txFinish
        || (ctrlWrite ? sfrWrData[TX_DONE_BIT] : txDone_r);

    rx_line_filter lineFilter (
        .clk(clk),
        .rstn(rstn),
        .pinIn(receiveLinePin),
        .sampleTick(timerOverflow),
        .level(lineLevel),
        .vote(lineVote)
    );

    // Control register; flags change only by hardware set or control write
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxDone_r <= CONTROL_RESET[RX_DONE_BIT];
            txDone_r <= CONTROL_RESET[TX_DONE_BIT];
            rxEnable_r <= CONTROL_RESET[RX_ENABLE_BIT];
            mpCheck_r <= CONTROL_RESET[MP_CHECK_BIT];
        end
        else
        begin
            rxDone_r <= rxDone_nxt;
            txDone_r <= txDone_nxt;
            if (ctrlWrite)
            begin
                rxEnable_r <= sfrWrData[RX_ENABLE_BIT];
                mpCheck_r <= sfrWrData[MP_CHECK_BIT];
            end
        end
    end

    // Registered read data; unmapped reads return zero
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdData_r <= 8'h00;
        else if (dataRead)
            rdData_r <= rxBuffer_r;
        else if (ctrlRead)
            rdData_r <= statusWord;
        else if (sfrRdEn)
            rdData_r <= 8'h00;
    end

    // Transmitter; no holding buffer, so a write while busy is dropped
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            txBusy_r <= 1'b0;
            txLine_r <= 1'b1;
            txShift_r <= 10'h3ff;
            txDiv_r <= 4'h0;
            txBits_r <= 4'h0;
        end
        else if (txLoad)
        begin
            txBusy_r <= 1'b1;
            txLine_r <= 1'b0;
            txShift_r <= {1'b1, sfrWrData, 1'b0};
            txDiv_r <= 4'h0;
            txBits_r <= 4'h0;
        end
        else if (txBusy_r && timerOverflow)
        begin
            txDiv_r <= txDiv_r + 4'h1;
            if (txFinish)
            begin
                txBusy_r <= 1'b0;
                txLine_r <= 1'b1;
            end
            else if (txBitEnd)
            begin
                txShift_r <= txShiftNext;
                txLine_r <= txShiftNext[0];
                txBits_r <= txBits_r + 4'h1;
            end
        end
    end

    // Previous filtered sample, for start edge detection
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            prevLevel_r <= 1'b1;
        else if (timerOverflow)
            prevLevel_r <= lineLevel;
    end

    // Receiver; a start that votes high at its middle is a glitch
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxState_r <= RX_IDLE;
            rxCnt_r <= 4'h0;
            rxBits_r <= 3'h0;
            rxShift_r <= 8'h00;
        end
        else if (startEdge)
        begin
            rxState_r <= RX_START;
            rxCnt_r <= 4'h0;
        end
        else if (timerOverflow && rxState_r != RX_IDLE)
        begin
            rxCnt_r <= rxPhase;
            if (rxMid)
            begin
                case (rxState_r)
                    RX_START:
                    begin
                        rxState_r <= lineVote ? RX_IDLE : RX_DATA;
                        rxBits_r <= 3'h0;
                    end
                    RX_DATA:
                    begin
                        rxShift_r <= {lineVote, rxShift_r[7:1]};
                        rxBits_r <= rxBits_r + 3'h1;
                        if (rxBits_r == RX_LAST_BIT)
                            rxState_r <= RX_STOP;
                    end
                    default:
                        rxState_r <= RX_IDLE;
                endcase
            end
        end
    end

    // Receive buffer and stop bit, written only on an accepted frame
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxBuffer_r <= DATA_RESET;
            ninth_r <= CONTROL_RESET[NINTH_BIT];
        end
        else if (rxCommit)
        begin
            rxBuffer_r <= rxShift_r;
            ninth_r <= lineVote;
        end
    end

    assign sfrRdData = rdData_r;
    assign transmitLine = txLine_r;
    assign transmitDoneFlag = txDone_r;
    assign receiveDoneFlag = rxDone_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    txStartBit_a: assert property (
        txLoad |=> !transmitLine && txBusy_r)
        else $error("write did not start the start bit");
    txStopEnd_a: assert property (
        $fell(txBusy_r) |-> transmitLine
        && $past(transmitLine) && $past(txBits_r) == TX_LAST_BIT)
        else $error("frame did not end on the stop bit");
    txDoneSet_a: assert property (
        $fell(txBusy_r) |-> transmitDoneFlag)
        else $error("transmit done not set at frame end");
    rxDoneSet_a: assert property (rxCommit |=> receiveDoneFlag
        && rxBuffer_r == $past(rxShift_r))
        else $error("receive done or buffer not updated");
    dataRead_a: assert property (
        dataRead |=> sfrRdData == $past(rxBuffer_r))
        else $error("data read returned wrong byte");
    rxAlign_a: assert property (startEdge |=> rxCnt_r == 4'h0
        && rxState_r == RX_START)
        else $error("divider not realigned on start edge");
    rxDiscard_a: assert property (
        stopMid && rxDone_r |=> $stable(rxBuffer_r))
        else $error("byte stored while receive done set");
    txBaud_a: assert property ($changed(transmitLine)
        |-> $past(timerOverflow) || $past(txLoad))
        else $error("line moved without an overflow");
    flagHold_a: assert property (receiveDoneFlag && !ctrlWrite
        |=> receiveDoneFlag)
        else $error("receive done dropped without a clear");
endmodule

// *** tb/remote_serial_end.sv ***
// Far-end serial transmitter and receiver model for the byte port
`timescale 1ns/10ps
module remote_serial_end
(
    // Clock and bit-rate tick
    input wire logic clk,
    input wire logic tick,
    // Serial lines
    input wire logic lineIn,
    output logic lineOut,
    // Last decoded frame
    output logic [7:0] gotByte,
    output logic gotStop
);
    // Wait a number of bit-rate ticks
    task automatic wait_ticks(input int n);
        repeat (n) @(posedge clk iff tick);
    endtask

    // Send start, eight data bits LSB first, then the given stop level
    task automatic send_frame(input logic [7:0] b, input logic stopBit);
        logic [9:0] bits;
        bits = {stopBit, b, 1'b0};
        // Line moves on a falling edge, away from the sampling edge
        for (int i = 0; i < 10; i++)
        begin
            lineOut = bits[i];
            wait_ticks(16);
            @(negedge clk);
        end
        lineOut = 1'b1;
    endtask

    // Short low pulse that must not be taken as a character
    task automatic glitch();
        lineOut = 1'b0;
        wait_ticks(3);
        @(negedge clk);
        lineOut = 1'b1;
    endtask

    // Decode frames at mid-bit; line idles high as with a pull-up
    initial
    begin
        lineOut = 1'b1;
        gotByte = 8'h00;
        gotStop = 1'b0;
        forever
        begin
            @(negedge lineIn);
            wait_ticks(8);
            for (int i = 0; i < 8; i++)
            begin
                wait_ticks(16);
                gotByte[i] = lineIn;
            end
            wait_ticks(16);
            gotStop = lineIn;
        end
    end
endmodule

// *** tb/serial_port_byte_transfer_tb.sv ***
// Self-checking bench for the serial port byte transfer block
`timescale 1ns/10ps
module serial_port_byte_transfer_tb
    import serial_port_pkg::*;
;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] sfrAddr = 8'h00;
    logic sfrWrEn = 1'b0;
    logic sfrRdEn = 1'b0;
    logic [7:0] sfrWrData = 8'h00;
    logic [7:0] sfrRdData;
    logic timerOverflow = 1'b0;
    logic receiveLinePin;
    logic transmitLine;
    logic transmitDoneFlag;
    logic receiveDoneFlag;
    logic [7:0] gotByte;
    logic gotStop;
    logic [7:0] txBytes [3] = '{8'ha5, 8'h5a, 8'h80};
    int failures = 0;
    int compares = 0;
    int n;

    serial_port_byte_transfer i_dut (.clk(clk), .rstn(rstn),
        .sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
        .sfrWrData(sfrWrData), .sfrRdData(sfrRdData),
        .timerOverflow(timerOverflow), .receiveLinePin(receiveLinePin),
        .transmitLine(transmitLine), .transmitDoneFlag(transmitDoneFlag),
        .receiveDoneFlag(receiveDoneFlag));

    remote_serial_end i_far (.clk(clk), .tick(timerOverflow),
        .lineIn(transmitLine), .lineOut(receiveLinePin),
        .gotByte(gotByte), .gotStop(gotStop));

    // 125 MHz clock; overflow every second cycle keeps frames short
    always #4 clk = ~clk;
    always @(negedge clk) timerOverflow <= ~timerOverflow;

    // Comparison, verdict and register access
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run();
        $display("Compares %0d, failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfrAddr = a;
        sfrWrData = d;
        sfrWrEn = 1'b1;
        @(negedge clk);
        sfrWrEn = 1'b0;
        // Let an edge pass so a following write raises the strobe anew
        @(negedge clk);
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
        sfrAddr = a;
        sfrRdEn = 1'b1;
        @(negedge clk);
        sfrRdEn = 1'b0;
        @(negedge clk);
        chk(sfrRdData, exp);
    endtask

    // Bounded wait for a flag; n counts the cycles taken
    task automatic wait_flag(input logic rx);
        n = 0;
        while ((rx ? receiveDoneFlag : transmitDoneFlag) !== 1'b1 && n < 2000)
        begin
            @(negedge clk);
            n++;
        end
    endtask

    // Far end sends one frame; flag and buffer are then compared
    task automatic rx_case(input logic [7:0] b, input logic s,
                           input logic fl, input logic [7:0] d);
        i_far.send_frame(b, s);
        repeat (40) @(negedge clk);
        chk({7'h0, receiveDoneFlag}, {7'h0, fl});
        rdchk(SERIAL_DATA_OFFSET, d);
    endtask

    // Watchdog: the whole sequence needs well under 6000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        complete_run();
    end

    // Main sequence
    initial
    begin
        repeat (4) @(negedge clk);
        rstn = 1'b1;
        chk({7'h0, transmitLine}, 8'h01);
        rdchk(SERIAL_DATA_OFFSET, DATA_RESET);
        rdchk(SERIAL_CONTROL_OFFSET, CONTROL_RESET);
        rdchk(8'h50, 8'h00);
        // Back-to-back transmits, each with a refused overwrite
        foreach (txBytes[i])
        begin
            wr(SERIAL_CONTROL_OFFSET, 8'h10);
            wr(SERIAL_DATA_OFFSET, txBytes[i]);
            chk({7'h0, transmitLine}, 8'h00);
            rdchk(SERIAL_CONTROL_OFFSET, 8'h18);
            wr(SERIAL_DATA_OFFSET, ~txBytes[i]);
            wait_flag(1'b0);
            // 160 overflows, one every second cycle, less the bus time
            chk({7'h0, (n >= 310 && n <= 320)}, 8'h01);
            chk(gotByte, txBytes[i]);
            chk({7'h0, gotStop}, 8'h01);
            rdchk(SERIAL_DATA_OFFSET, 8'h00);
            chk({7'h0, transmitDoneFlag}, 8'h01);
        end
        // Receive, drop while flag set, multiprocessor check, glitch
        rx_case(8'h3c, 1'b1, 1'b1, 8'h3c);
        rdchk(SERIAL_CONTROL_OFFSET, 8'h17);
        rx_case(8'h77, 1'b1, 1'b1, 8'h3c);
        wr(SERIAL_CONTROL_OFFSET, 8'h30);
        chk({7'h0, receiveDoneFlag}, 8'h00);
        rx_case(8'h11, 1'b0, 1'b0, 8'h3c);
        rx_case(8'h22, 1'b1, 1'b1, 8'h22);
        wr(SERIAL_CONTROL_OFFSET, 8'h10);
        i_far.glitch();
        repeat (400) @(negedge clk);
        chk({7'h0, receiveDoneFlag}, 8'h00);
        complete_run();
    end
endmodule
